// ---- hw/sbr_pkg.sv ----
// shared constants and carrier types for the sample and reading store controller
// assumes an apb master with 32-bit data and byte addresses in the low eight bits
package sbr_pkg;

  // register byte offsets
  localparam logic [7:0] SBR_OFF_CTRL = 8'h00;
  localparam logic [7:0] SBR_OFF_CMD = 8'h04;
  localparam logic [7:0] SBR_OFF_DATA = 8'h08;
  localparam logic [7:0] SBR_OFF_STATUS = 8'h0c;
  localparam logic [7:0] SBR_OFF_PTRS = 8'h10;

  // control register fields
  localparam int SBR_CTRL_WAVE_BIT = 0;
  localparam int SBR_CTRL_MODE_LSB = 1;
  localparam int SBR_CTRL_DCLR_BIT = 3;
  localparam logic [31:0] SBR_CTRL_RESET = 32'h0000_0000;

  // command register fields: signed argument low, opcode above it
  localparam int SBR_ARG_W = 16;
  localparam int SBR_CMD_OP_LSB = 16;

  // data register fields
  localparam int SBR_DW = 16;
  localparam int SBR_DATA_CNT_LSB = 16;
  localparam int SBR_DATA_SRC_LSB = 28;
  localparam logic [1:0] SBR_SRC_LIVE = 2'h0;
  localparam logic [1:0] SBR_SRC_SAMPLE = 2'h1;
  localparam logic [1:0] SBR_SRC_STORE = 2'h2;

  // reading store geometry
  localparam int SBR_READ_DEPTH = 100;
  localparam int SBR_CNT_W = 7;
  localparam logic [SBR_CNT_W-1:0] SBR_READ_FULL = 7'h64;

  typedef enum logic [1:0] {
    reading_store_off = 2'h0,
    linear_store_mode = 2'h1,
    circular_store_mode = 2'h2
  } sbr_mode_type;

  typedef enum logic [1:0] {
    clear_waveform_output_cmd = 2'h0,
    sample_start_pointer_cmd = 2'h1,
    sample_end_pointer_cmd = 2'h2,
    reading_start_pointer_cmd = 2'h3
  } sbr_cmd_type;

  typedef struct packed {
    logic valid;
    logic [SBR_DW-1:0] value;
  } sbr_reading_type;

endpackage : sbr_pkg

// ---- hw/sbr_ctrl.sv ----
// sample store and processed reading store controller with an apb register port
// assumes sample, reading and waveform-done strobes come from logic on pclk
`timescale 1ns/100ps
module sbr_ctrl
  import sbr_pkg::*;
#(
  parameter int SDEPTH = 256
) (
  input wire logic pclk, // 20 mhz bus clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data, registered
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic meas_start, // pulse: a new measurement begins
  input wire sbr_reading_type sample_in, // converter sample strobe
  input wire sbr_reading_type chan0_reading, // processed reading, channel 0
  input wire sbr_reading_type chan1_reading, // processed reading, channel 1
  input wire logic wave_done, // pulse: a complete waveform is ready
  input wire logic [SBR_DW-1:0] live_reading // current reading of the active function
);

  localparam int SW = $clog2(SDEPTH);

  // all state lives in one record: a single comb block builds the next copy and
  // a single register stage holds it, so every field resets in the same place.
  // the sample ring and the reading store are flip-flop arrays; sdepth trades
  // area for how far back a negative start pointer can still reach.
  typedef struct packed {
    logic [SDEPTH-1:0][SBR_DW-1:0] smem;
    logic [SW-1:0] wbase;
    logic [SW-1:0] wptr;
    logic [SW:0] mcount;
    logic signed [SBR_ARG_W-1:0] start;
    logic signed [SBR_ARG_W-1:0] stop;
    logic signed [SBR_ARG_W-1:0] pos;
    logic limited;
    logic wave;
    logic wave_pending;
    logic rejected;
    sbr_mode_type mode;
    logic [SBR_READ_DEPTH-1:0][SBR_DW-1:0] rmem;
    logic [SBR_CNT_W-1:0] rd;
    logic [SBR_CNT_W-1:0] wr;
    logic [SBR_CNT_W-1:0] fill;
    logic locked;
    logic [31:0] rdata;
    logic err;
  } sbr_state_type;

  sbr_state_type s;
  sbr_state_type next_s;

  // physical sample location of sample number off relative to the measurement base
  function automatic logic [SW-1:0] sample_addr(input logic [SW-1:0] base, input int off);
    int t;
    t = (int'(base) + off) % SDEPTH;
    if (t < 0) begin
      t = t + SDEPTH;
    end
    return SW'(t);
  endfunction : sample_addr

  // store pointers wrap at the store depth, not at the counter width, so the
  // unused codes above the depth are never reached
  function automatic logic [SBR_CNT_W-1:0] rnext(input logic [SBR_CNT_W-1:0] p);
    return (p == SBR_READ_FULL - 7'h01) ? 7'h00 : p + 7'h01;
  endfunction : rnext

  function automatic logic [SBR_CNT_W-1:0] rprev(input logic [SBR_CNT_W-1:0] p);
    return (p == 7'h00) ? SBR_READ_FULL - 7'h01 : p - 7'h01;
  endfunction : rprev

  // data register word: source code, readings left, value
  function automatic logic [31:0] data_word(input logic [1:0] src,
                                            input logic [SBR_CNT_W-1:0] cnt,
                                            input logic [SBR_DW-1:0] v);
    return {2'h0, src, 5'h0, cnt, v};
  endfunction : data_word

  // unmapped offsets answer with an error and read as zero
  function automatic logic mapped(input logic [7:0] a);
    logic hit;
    unique case (a)
      SBR_OFF_CTRL, SBR_OFF_CMD, SBR_OFF_DATA, SBR_OFF_STATUS, SBR_OFF_PTRS: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : mapped

  // order inside this block matters: capture first, then the read side effects
  // of a setup cycle, then the write of an access cycle. a reading that lands in
  // the same cycle as a pop is therefore stored before the pop looks at the fill,
  // and a command sees the store as it stands after both.

  always_comb begin
    int arg;
    int posi;
    logic [SW-1:0] sa;
    sbr_reading_type rin [2];
    sbr_mode_type wmode;
    arg = int'($signed(pwdata[SBR_ARG_W-1:0]));
    posi = int'(s.pos);
    sa = sample_addr(s.wbase, posi);
    rin[0] = chan0_reading;
    rin[1] = chan1_reading;
    wmode = sbr_mode_type'(pwdata[SBR_CTRL_MODE_LSB +: 2]);
    next_s = s;

    // sample capture into the ring; older measurements stay until overwritten
    if (meas_start) begin
      next_s.wbase = s.wptr;
      next_s.mcount = '0;
    end
    if (sample_in.valid) begin
      next_s.smem[s.wptr] = sample_in.value;
      next_s.wptr = sample_addr(s.wptr, 1);
      if (next_s.mcount < (SW+1)'(SDEPTH)) begin
        next_s.mcount = next_s.mcount + 1'b1;
      end
    end

    // reading capture
    // in waveform function only the ring base of the latest whole waveform is stored, in slot 0;
    // channel readings are ignored there so the two kinds never mix
    if (s.mode != reading_store_off) begin
      if (s.wave) begin
        if (wave_done) begin
          // a new waveform replaces whatever was stored before
          next_s.rmem[0] = SBR_DW'(s.wbase);
          next_s.rd = '0;
          next_s.wr = 7'h01;
          next_s.fill = 7'h01;
          next_s.locked = 1'b0;
        end
      end else begin
        // channel 0 first when both finish together, each takes the next slot
        for (int c = 0; c < 2; c++) begin
          if (rin[c].valid) begin
            if (next_s.fill == SBR_READ_FULL && s.mode == circular_store_mode) begin
              // circular overwrites the oldest so readout stays oldest first
              next_s.rmem[next_s.wr] = rin[c].value;
              next_s.wr = rnext(next_s.wr);
              next_s.rd = rnext(next_s.rd);
            end else if (next_s.fill < SBR_READ_FULL && !next_s.locked) begin
              next_s.rmem[next_s.wr] = rin[c].value;
              next_s.wr = rnext(next_s.wr);
              next_s.fill = next_s.fill + 7'h01;
              if (next_s.fill == SBR_READ_FULL && s.mode == linear_store_mode) begin
                next_s.locked = 1'b1;
              end
            end
          end
        end
      end
    end

    // setup phase: decode, latch read data, and perform read side effects
    // the pop happens here rather than in the access phase so that prdata is a
    // plain register through the access cycle and pready can stay tied high
    if (psel && !penable) begin
      next_s.err = !mapped(paddr);
      next_s.rdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          SBR_OFF_CTRL: begin
            next_s.rdata = {28'h0, 1'b0, s.mode, s.wave};
          end
          SBR_OFF_STATUS: begin
            next_s.rdata = {20'h0, s.locked, s.rejected, s.wave_pending, s.limited, 1'b0,
                            s.fill};
          end
          SBR_OFF_PTRS: begin
            next_s.rdata = {s.stop, s.start};
          end
          SBR_OFF_DATA: begin
            if (s.wave || s.wave_pending) begin
              next_s.rdata = data_word(SBR_SRC_SAMPLE, 7'h00, s.smem[sa]);
              if (s.limited) begin
                if (s.pos >= s.stop) begin
                  next_s.limited = 1'b0;
                  next_s.pos = '0;
                end else begin
                  next_s.pos = s.pos + 16'sh0001;
                end
              end else if (posi + 1 >= int'(s.mcount) || posi < 0) begin
                next_s.pos = '0;
              end else begin
                next_s.pos = s.pos + 16'sh0001;
              end
            end else if (s.mode != reading_store_off) begin
              if (next_s.fill != 7'h00) begin
                next_s.rdata = data_word(SBR_SRC_STORE, next_s.fill - 7'h01,
                                         next_s.rmem[next_s.rd]);
                next_s.rd = rnext(next_s.rd);
                next_s.fill = next_s.fill - 7'h01;
                if (next_s.fill == 7'h00) begin
                  next_s.locked = 1'b0;
                end
              end else begin
                // an empty store answers with a zero count and leaves the pointers
                next_s.rdata = data_word(SBR_SRC_STORE, 7'h00, next_s.rmem[next_s.rd]);
              end
            end else begin
              next_s.rdata = data_word(SBR_SRC_LIVE, 7'h00, live_reading);
            end
          end
          default: begin
            next_s.rdata = '0;
          end
        endcase
      end
    end

    // access phase: writes take effect here
    // a refused command leaves every pointer as it was and only raises the
    // rejected flag, which the next accepted command clears again
    if (psel && penable && pwrite) begin
      if (paddr == SBR_OFF_CTRL) begin
        next_s.wave = pwdata[SBR_CTRL_WAVE_BIT];
        if (s.wave && !pwdata[SBR_CTRL_WAVE_BIT] && (s.limited || s.pos != 16'sh0000)) begin
          next_s.wave_pending = 1'b1;
        end
        if (pwdata[SBR_CTRL_DCLR_BIT]) begin
          next_s.mode = reading_store_off;
        end else if (wmode == reading_store_off || wmode == linear_store_mode ||
                     wmode == circular_store_mode) begin
          next_s.mode = wmode;
        end else begin
          next_s.rejected = 1'b1;
        end
        if (next_s.mode == reading_store_off) begin
          next_s.fill = '0;
          next_s.rd = '0;
          next_s.wr = '0;
          next_s.locked = 1'b0;
        end
      end else if (paddr == SBR_OFF_CMD) begin
        unique case (sbr_cmd_type'(pwdata[SBR_CMD_OP_LSB +: 2]))
          clear_waveform_output_cmd: begin
            // one command serves both stores: restart the sample readout and,
            // with the store on, give back the last reading that was popped
            next_s.pos = '0;
            next_s.limited = 1'b0;
            next_s.wave_pending = 1'b0;
            if (s.mode != reading_store_off) begin
              next_s.rd = rprev(next_s.rd);
              if (next_s.fill < SBR_READ_FULL) begin
                next_s.fill = next_s.fill + 7'h01;
              end
            end
            next_s.rejected = 1'b0;
          end
          sample_start_pointer_cmd: begin
            // negative start only while the earlier samples survive in the ring
            // the ring keeps sdepth samples in all, so whatever the current
            // measurement has not yet written still holds the previous one
            if (arg >= SDEPTH || (arg < 0 && -arg > SDEPTH - int'(s.mcount))) begin
              next_s.rejected = 1'b1;
            end else begin
              next_s.start = $signed(pwdata[SBR_ARG_W-1:0]);
              next_s.pos = $signed(pwdata[SBR_ARG_W-1:0]);
              next_s.limited = 1'b1;
              next_s.rejected = 1'b0;
            end
          end
          sample_end_pointer_cmd: begin
            // the end may equal the start, giving a pass of a single sample
            if (arg > SDEPTH - 1 || arg < int'(s.start)) begin
              next_s.rejected = 1'b1;
            end else begin
              next_s.stop = $signed(pwdata[SBR_ARG_W-1:0]);
              next_s.pos = s.start;
              next_s.limited = 1'b1;
              next_s.rejected = 1'b0;
            end
          end
          reading_start_pointer_cmd: begin
            // m counts from one, so slot m-1 is read next and m readings remain
            if (arg < 1 || arg > SBR_READ_DEPTH) begin
              next_s.rejected = 1'b1;
            end else begin
              next_s.rd = SBR_CNT_W'(arg - 1);
              next_s.fill = SBR_CNT_W'(arg);
              next_s.rejected = 1'b0;
            end
          end
        endcase
      end
    end
  end

  // reset gives mode off and waveform function off; the stores are zeroed along with
  // every other field, since an empty store read still returns the slot at the read pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.mode <= reading_store_off;
      s.wave <= SBR_CTRL_RESET[SBR_CTRL_WAVE_BIT];
    end else begin
      s <= next_s;
    end
  end

  // zero wait states: data is latched in setup and presented for the access phase
  // limitation: a master that skips the setup cycle would read stale data
  assign pready = 1'b1;
  assign pslverr = psel & penable & s.err;
  assign prdata = s.rdata;

endmodule : sbr_ctrl

// ---- tb/sbr_ctrl_chk.sv ----
// apb port assertions for the sample and reading store controller
// assumes binding into sbr_ctrl; sees only its ports
`timescale 1ns/100ps
module sbr_ctrl_chk
  import sbr_pkg::*;
#(
  parameter int SDEPTH = 256
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {SBR_OFF_CTRL, SBR_OFF_CMD, SBR_OFF_DATA, SBR_OFF_STATUS,
    SBR_OFF_PTRS};
  sequence rd_at(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a ##1 psel && penable;
  endsequence
  AST_READY: assert property (pready) else $error("pready low");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable) else $error("late pslverr");
  AST_UNMAPPED: assert property (psel && penable && !mapped |-> pslverr
    && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  AST_MAPPED: assert property (psel && penable && mapped |-> !pslverr) else $error("bad pslverr");
  AST_HOLD: assert property (psel && penable |=> $stable(prdata) || (psel && !penable))
    else $error("prdata moved after access");
  AST_CMD_RD0: assert property (rd_at(SBR_OFF_CMD) |-> prdata == 32'h0) else $error("cmd read");
  AST_CTRL_RD: assert property (rd_at(SBR_OFF_CTRL) |-> !prdata[3] && prdata[2:1] != 2'h3)
    else $error("ctrl read");
  AST_DATA_CNT: assert property (rd_at(SBR_OFF_DATA) |-> prdata[22:16] <= SBR_READ_FULL
    && prdata[29:28] != 2'h3) else $error("data word");
  AST_FILL: assert property (rd_at(SBR_OFF_STATUS) |-> prdata[6:0] <= SBR_READ_FULL)
    else $error("fill above depth");
  AST_END_PTR: assert property (rd_at(SBR_OFF_PTRS) |-> prdata[31:16] < SDEPTH)
    else $error("end pointer range");
endmodule : sbr_ctrl_chk
bind sbr_ctrl sbr_ctrl_chk #(.SDEPTH(SDEPTH)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// ---- tb/sbr_host.sv ----
// bus controller model: apb master issuing commands and data requests
// assumes the slave answers with pready within the bench timeout
`timescale 1ns/100ps
module sbr_host (
  input wire logic pclk, // clock
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // write
  output logic [7:0] paddr, // address
  output logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd_d, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic y;
    xfer(1'b1, a, wd, x, y);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic e);
    xfer(1'b0, a, 32'h0, d, e);
  endtask : rd
endmodule : sbr_host

// ---- tb/tb_top.sv ----
// self-checking bench for sbr_ctrl: apb calls plus sample and reading strobes
// assumes a small sample ring so pointer limits are cheap to reach
`timescale 1ns/100ps
module tb_top;
  import sbr_pkg::*;
  localparam int SD = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, meas_start, wave_done, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [15:0] live_reading;
  sbr_reading_type sample_in, chan0_reading, chan1_reading;
  int err_count, n_checks;
  sbr_ctrl #(.SDEPTH(SD)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_start(meas_start), .sample_in(sample_in),
    .chan0_reading(chan0_reading), .chan1_reading(chan1_reading), .wave_done(wave_done),
    .live_reading(live_reading));
  sbr_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input string nm, input logic [31:0] seen, exp, m);
    n_checks++;
    if ((seen & m) !== (exp & m)) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp & m, seen & m);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, m, input string nm);
    host.rd(a, d, e);
    chk(nm, d, exp, m);
  endtask : rd
  task automatic dat(input logic [1:0] src, input logic [6:0] c, input logic [15:0] v);
    rd(SBR_OFF_DATA, {2'h0, src, 5'h0, c, v},
      (src == SBR_SRC_STORE) ? 32'h307f_ffff : 32'h3000_ffff, "data");
  endtask : dat
  task automatic cmd(input sbr_cmd_type op, input logic [15:0] m);
    host.wr(SBR_OFF_CMD, {14'h0, op, m});
  endtask : cmd
  task automatic rdg(input logic [15:0] v0, input logic two, input logic [15:0] v1);
    @(posedge pclk);
    chan0_reading <= '{1'b1, v0};
    chan1_reading <= '{two, v1};
    @(posedge pclk);
    chan0_reading <= '0;
    chan1_reading <= '0;
  endtask : rdg
  task automatic smp(input logic [15:0] v);
    @(posedge pclk);
    sample_in <= '{1'b1, v};
    @(posedge pclk);
    sample_in <= '0;
  endtask : smp
  task automatic strobe(input logic ms, input logic wd);
    @(posedge pclk);
    meas_start <= ms;
    wave_done <= wd;
    @(posedge pclk);
    meas_start <= 1'b0;
    wave_done <= 1'b0;
  endtask : strobe
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    report_and_stop();
  end
  initial begin
    {presetn, meas_start, wave_done} = 3'h0;
    {sample_in, chan0_reading, chan1_reading} = '0;
    live_reading = 16'h5a5a;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(SBR_OFF_CTRL, 32'h0, 32'hffff_ffff, "ctrl reset");
    rd(SBR_OFF_STATUS, 32'h0, 32'h7f, "fill reset");
    for (int q = 1; q <= 2; q++) begin
      host.wr(SBR_OFF_CTRL, 32'h8);
      host.wr(SBR_OFF_CTRL, 32'(q << 1));
      for (int k = 0; k <= 100; k++) rdg(16'(k), 1'b0, 16'h0);
      rd(SBR_OFF_STATUS, (q == 1) ? 32'h864 : 32'h64, 32'h87f, "full");
      dat(SBR_SRC_STORE, 7'h63, (q == 1) ? 16'h0 : 16'h1);
      dat(SBR_SRC_STORE, 7'h62, (q == 1) ? 16'h1 : 16'h2);
      for (int k = 0; k < 98; k++) host.rd(SBR_OFF_DATA, d, e);
      rdg(16'h77, 1'b0, 16'h0);
      dat(SBR_SRC_STORE, 7'h0, 16'h77);
    end
    host.wr(SBR_OFF_CTRL, 32'h8);
    host.wr(SBR_OFF_CTRL, 32'h2);
    rdg(16'h10, 1'b1, 16'h11);
    rdg(16'h12, 1'b1, 16'h13);
    rdg(16'h14, 1'b0, 16'h0);
    cmd(reading_start_pointer_cmd, 16'h3);
    dat(SBR_SRC_STORE, 7'h2, 16'h12);
    cmd(clear_waveform_output_cmd, 16'h0);
    dat(SBR_SRC_STORE, 7'h2, 16'h12);
    host.wr(SBR_OFF_CTRL, 32'h6);
    rd(SBR_OFF_CTRL, 32'h2, 32'h7, "mode 3");
    rd(SBR_OFF_STATUS, 32'h400, 32'h400, "mode 3 refused");
    host.wr(SBR_OFF_CTRL, 32'h8);
    host.wr(SBR_OFF_CTRL, 32'h1);
    strobe(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) smp(16'h200 + 16'(i));
    strobe(1'b1, 1'b0);
    for (int i = 0; i < 8; i++) smp(16'h100 + 16'(i));
    dat(SBR_SRC_SAMPLE, 7'h0, 16'h100);
    dat(SBR_SRC_SAMPLE, 7'h0, 16'h101);
    cmd(clear_waveform_output_cmd, 16'h0);
    dat(SBR_SRC_SAMPLE, 7'h0, 16'h100);
    cmd(sample_start_pointer_cmd, 16'h2);
    cmd(sample_end_pointer_cmd, 16'h4);
    for (int i = 2; i <= 4; i++) dat(SBR_SRC_SAMPLE, 7'h0, 16'h100 + 16'(i));
    dat(SBR_SRC_SAMPLE, 7'h0, 16'h100);
    for (int i = 0; i < 2; i++) begin
      cmd(sample_end_pointer_cmd, (i == 0) ? 16'h1 : 16'(SD));
      rd(SBR_OFF_PTRS, 32'h0004_0002, 32'hffff_ffff, "ptrs kept");
      rd(SBR_OFF_STATUS, 32'h400, 32'h400, "end refused");
    end
    cmd(sample_start_pointer_cmd, 16'hfffe);
    dat(SBR_SRC_SAMPLE, 7'h0, 16'h202);
    dat(SBR_SRC_SAMPLE, 7'h0, 16'h203);
    dat(SBR_SRC_SAMPLE, 7'h0, 16'h100);
    host.wr(SBR_OFF_CTRL, 32'h0);
    dat(SBR_SRC_SAMPLE, 7'h0, 16'h101);
    cmd(clear_waveform_output_cmd, 16'h0);
    dat(SBR_SRC_LIVE, 7'h0, 16'h5a5a);
    host.wr(SBR_OFF_CTRL, 32'h8);
    host.wr(SBR_OFF_CTRL, 32'h3);
    strobe(1'b1, 1'b1);
    strobe(1'b1, 1'b1);
    rd(SBR_OFF_STATUS, 32'h1, 32'h7f, "one waveform");
    rd(SBR_OFF_CMD, 32'h0, 32'hffff_ffff, "cmd reads zero");
    rd(8'h14, 32'h0, 32'hffff_ffff, "unmapped");
    chk("slverr", {31'h0, e}, 32'h1, 32'h1);
    report_and_stop();
  end
endmodule : tb_top
